// ---- tap_host.sv ----
// Behavioural outside test controller that drives four of the five test pins and samples the serial output
`timescale 1ns/10ps
module tap_host (
    input wire logic i_clk,
    input wire logic i_tdo_pin,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    initial begin
        o_tck = 1'b1;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_trst_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One test clock period of 17 system cycles (85 ns), ending parked high
    task automatic bit_cycle(input logic tms_v, input logic tdi_v, output logic tdo_v);
        @(posedge i_clk);
        o_tck <= 1'b0;
        o_tms <= tms_v;
        o_tdi <= tdi_v;
        repeat (8) @(posedge i_clk);
        tdo_v = i_tdo_pin;
        o_tck <= 1'b1;
        repeat (8) @(posedge i_clk);
        // Hold time over: data line falls back to its pull-up
        o_tdi <= 1'b1;
    endtask : bit_cycle

    // Test reset pulse while the clock stays parked high
    task automatic trst_pulse(input int n);
        @(posedge i_clk);
        o_trst_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_trst_n <= 1'b1;
    endtask : trst_pulse
endmodule : tap_host

// ---- tap_pkg.sv ----
// Constants and state encoding for the boundary-scan test access port
// Functional notes
// R1: Each rising test clock edge samples mode select into the controller and data input into the selected register.
// R2: Test data output changes only on falling test clock edges.
// R3: The outside controller holds the test clock high whenever it stops it.
// R4: While shifting, the serial input enters the least significant bit of the selected register.
// R5: While shifting, the serial output presents the most significant bit of the selected register.
// R6: The test data output is released except while a data or instruction shift is in progress.
// R7: Test reset low forces the controller into its reset state regardless of clock or mode select.
// R8: Five serial pins and a sixteen-state controller govern every scan operation.
// R9: A bypass path passes data from input to output through one clocked stage.
// R10: In data shift the selected data register moves one stage toward the output per rising edge, others hold.
// R11: Run-test/idle is encoded 0xC and is held while mode select is low.
// R12: Transitions follow the standard state graph; five edges with mode select high reach reset from anywhere.
// R13: While the controller is in reset the instruction register selects the bypass path.
package tap_pkg;
    localparam int IR_WIDTH = 4;
    localparam int DR_WIDTH = 32;
    localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_WIDTH-1:0] IR_USER = 4'h1;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        ST_EXIT2_DR = 4'h0,
        ST_EXIT1_DR = 4'h1,
        ST_SHIFT_DR = 4'h2,
        ST_PAUSE_DR = 4'h3,
        ST_SEL_IR = 4'h4,
        ST_UPD_DR = 4'h5,
        ST_CAP_DR = 4'h6,
        ST_SEL_DR = 4'h7,
        ST_EXIT2_IR = 4'h8,
        ST_EXIT1_IR = 4'h9,
        ST_SHIFT_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_IDLE = 4'hc,
        ST_UPD_IR = 4'hd,
        ST_CAP_IR = 4'he,
        ST_RESET = 4'hf
    } tap_state_type;
endpackage : tap_pkg

// ---- tap_port.sv ----
// Test access port: controller, instruction register, bypass and user data register
`timescale 1ns/10ps
module tap_port #(
    parameter int DR_BITS = tap_pkg::DR_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic [DR_BITS-1:0] i_capture_data,
    output logic o_tdo,
    output logic o_tdo_oe,
    output logic [DR_BITS-1:0] o_update_data,
    output logic o_update_pulse,
    output tap_pkg::tap_state_type o_state,
    output logic [tap_pkg::IR_WIDTH-1:0] o_instr
);
    import tap_pkg::*;

    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst_n;
    tap_state_type state;
    tap_state_type next_state;
    logic [IR_WIDTH-1:0] ir_shift;
    logic [IR_WIDTH-1:0] ir;
    logic bypass;
    logic [DR_BITS-1:0] dr_shift;
    logic next_tdo;
    logic [2:0] high_edges;

    tap_sync u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_tck(i_tck),
        .i_tms(i_tms),
        .i_tdi(i_tdi),
        .i_trst_n(i_trst_n),
        .o_tck_rise(tck_rise),
        .o_tck_fall(tck_fall),
        .o_tms(tms),
        .o_tdi(tdi),
        .o_trst_n(trst_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Controller

    always_comb begin
        case (state) // R12
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE; // R11
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // Test reset overrides any edge, whatever mode select shows
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !trst_n) begin // R7
            state <= ST_RESET;
        end else if (tck_rise) begin // R1 R8
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction register

    always_ff @(posedge i_clk) begin
        if (!i_resetn || !trst_n) begin
            ir_shift <= IR_BYPASS;
        end else if (tck_rise) begin
            if (state == ST_CAP_IR) begin
                ir_shift <= IR_CAPTURE;
            end else if (state == ST_SHIFT_IR) begin
                ir_shift <= {ir_shift[IR_WIDTH-2:0], tdi}; // R4
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || !trst_n || state == ST_RESET) begin // R13
            ir <= IR_BYPASS;
        end else if (tck_rise && state == ST_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data registers

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            bypass <= 1'b0;
        end else if (tck_rise && ir != IR_USER) begin
            if (state == ST_CAP_DR) begin
                bypass <= 1'b0;
            end else if (state == ST_SHIFT_DR) begin
                bypass <= tdi; // R9
            end
        end
    end

    // Only the selected register moves; the other holds
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            dr_shift <= '0;
        end else if (tck_rise && ir == IR_USER) begin
            if (state == ST_CAP_DR) begin
                dr_shift <= i_capture_data;
            end else if (state == ST_SHIFT_DR) begin
                dr_shift <= {dr_shift[DR_BITS-2:0], tdi}; // R10 R4
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_update_data <= '0;
            o_update_pulse <= 1'b0;
        end else begin
            o_update_pulse <= tck_rise && state == ST_UPD_DR && ir == IR_USER;
            if (tck_rise && state == ST_UPD_DR && ir == IR_USER) begin
                o_update_data <= dr_shift;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output, launched on the falling edge

    always_comb begin
        if (state == ST_SHIFT_IR) begin
            next_tdo = ir_shift[IR_WIDTH-1];
        end else if (ir == IR_USER) begin
            next_tdo = dr_shift[DR_BITS-1];
        end else begin
            next_tdo = bypass;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin // R2
            o_tdo <= next_tdo; // R5
            o_tdo_oe <= state == ST_SHIFT_DR || state == ST_SHIFT_IR; // R6
        end else if (!trst_n) begin
            o_tdo_oe <= 1'b0;
        end
    end

    assign o_state = state;
    assign o_instr = ir;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Run of rising edges with mode select high, saturating at five so the check stays bounded
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !trst_n) begin
            high_edges <= 3'h0;
        end else if (tck_rise) begin
            if (!tms) begin
                high_edges <= 3'h0;
            end else if (high_edges != 3'h5) begin
                high_edges <= high_edges + 3'h1;
            end
        end
    end

    sequence s_tms_high_edge;
        tck_rise && tms && trst_n;
    endsequence

    a_trst_forces_reset: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
        !trst_n |=> state == ST_RESET) else $error("test reset did not reach reset state");

    a_idle_holds: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
        state == ST_IDLE && tck_rise && !tms && trst_n |=> state == ST_IDLE)
        else $error("idle left with mode select low");

    a_reset_code: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
        state == ST_RESET && tck_rise && !tms && trst_n |=> o_state == 4'hc) else $error("idle encoding wrong");

    a_state_on_edge: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
        !tck_rise && trst_n |=> $stable(state)) else $error("state moved without a clock edge");

    a_tdo_on_fall: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
        !tck_fall |=> $stable(o_tdo)) else $error("serial output changed off a falling edge");

    a_tdo_release: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
        tck_fall && state != ST_SHIFT_DR && state != ST_SHIFT_IR |=> !o_tdo_oe)
        else $error("serial output driven outside a shift");

    a_ir_bypass_reset: assert property (@(posedge i_clk) disable iff (!i_resetn) // R13
        state == ST_RESET |=> ir == IR_BYPASS) else $error("reset did not select bypass");

    a_bypass_stage: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
        tck_rise && state == ST_SHIFT_DR && ir != IR_USER && trst_n |=> bypass == $past(tdi))
        else $error("bypass stage did not take input");

    a_ir_shift_lsb: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
        tck_rise && state == ST_SHIFT_IR && trst_n |=> ir_shift[0] == $past(tdi))
        else $error("instruction bit did not enter low end");

    a_five_to_reset: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
        high_edges >= 3'h4 ##0 s_tms_high_edge |=> state == ST_RESET)
        else $error("five high edges did not reach reset");
endmodule : tap_port

// ---- tap_sync.sv ----
// Two-flop synchroniser with edge detection for the test pins
`timescale 1ns/10ps
module tap_sync (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    output logic o_tck_rise,
    output logic o_tck_fall,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    import tap_pkg::*;

    logic [3:0] meta;
    logic [3:0] sync;
    logic tck_prev;

    // Stage one is read only by stage two
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            meta <= 4'hb;
            sync <= 4'hb;
        end else begin
            meta <= {i_trst_n, i_tdi, i_tms, i_tck};
            sync <= meta;
        end
    end

    // Parked-high clock starts from high so no false edge after reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tck_prev <= 1'b1;
        end else begin
            tck_prev <= sync[0];
        end
    end

    assign o_tck_rise = sync[0] & ~tck_prev;
    assign o_tck_fall = ~sync[0] & tck_prev;
    assign o_tms = sync[1];
    assign o_tdi = sync[2];
    assign o_trst_n = sync[3];
endmodule : tap_sync

// ---- test_access_port_bench.sv ----
// Self-checking bench for the test access port
`timescale 1ns/10ps
module test_access_port_bench;
    import tap_pkg::*;
    logic i_clk;
    logic i_resetn;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, upd_pulse;
    logic [31:0] cap_data;
    logic [31:0] upd_data;
    tap_state_type state;
    logic [IR_WIDTH-1:0] instr;
    wire tdo_pin;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int pulses = 0;
    // No pull on the output: a released pin shows the inverse so a stray sample mismatches
    assign tdo_pin = tdo_oe ? tdo : ~tdo;

    tap_port i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .i_capture_data(cap_data), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .o_update_data(upd_data), .o_update_pulse(upd_pulse), .o_state(state), .o_instr(instr));
    tap_host i_host (.i_clk(i_clk), .i_tdo_pin(tdo_pin), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .o_trst_n(trst_n));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (upd_pulse === 1'b1) pulses++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic nav(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) i_host.bit_cycle(seq[i], 1'b1, b);
    endtask : nav

    // Sends MSB first, raising mode select with the last bit
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        for (int i = n - 1; i >= 0; i--) begin
            i_host.bit_cycle(i == 0, din[i], b);
            dout = {dout[30:0], b};
        end
    endtask : shift

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_idle();
        chk(state === ST_RESET && instr === IR_BYPASS && tdo_oe === 1'b0, "reset values");
        nav(8'h00, 4);
        chk(state === ST_IDLE, "idle not held with mode select low");
    endtask : t_reset_idle

    task automatic t_ir_load();
        logic [31:0] d;
        nav(8'h03, 4);
        chk(state === ST_SHIFT_IR, "shift-ir not reached");
        shift(4, {28'h0, IR_USER}, d);
        chk(d === {28'h0, IR_CAPTURE}, "instruction capture out");
        nav(8'h01, 3);
        chk(instr === IR_USER && state === ST_IDLE, "instruction load");
        chk(tdo_oe === 1'b0, "output driven in idle");
    endtask : t_ir_load

    task automatic t_user_dr();
        logic [31:0] d;
        int p0;
        p0 = pulses;
        nav(8'h01, 3);
        shift(32, 32'h1234_5678, d);
        chk(d === cap_data, "data capture out");
        nav(8'h01, 2);
        chk(upd_data === 32'h1234_5678, "data update");
        chk(pulses == p0 + 1, "update pulse count");
    endtask : t_user_dr

    task automatic t_bypass();
        logic [31:0] d;
        int p0;
        nav(8'h1f, 5);
        chk(state === ST_RESET && instr === IR_BYPASS, "five highs reach reset");
        p0 = pulses;
        nav(8'h02, 4);
        shift(8, 32'h0000_00b2, d);
        chk(d === 32'h0000_0059, "bypass one stage delay");
        nav(8'h01, 2);
        chk(pulses == p0 && upd_data === 32'h1234_5678, "bypass touched user data");
    endtask : t_bypass

    task automatic t_trst();
        logic b;
        nav(8'h01, 3);
        chk(state === ST_SHIFT_DR, "shift-dr not reached");
        i_host.bit_cycle(1'b0, 1'b1, b);
        chk(tdo_oe === 1'b1 && b === 1'b0 && state === ST_SHIFT_DR, "bypass shift output");
        i_host.trst_pulse(6);
        repeat (4) @(posedge i_clk);
        chk(state === ST_RESET && instr === IR_BYPASS && tdo_oe === 1'b0, "test reset");
    endtask : t_trst

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    initial begin
        i_resetn = 1'b0;
        cap_data = 32'ha5c3_0f96;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset_idle();
        t_ir_load();
        t_user_dr();
        t_bypass();
        t_trst();
        wrap_up();
    end
endmodule : test_access_port_bench
